/* inc/sense_pin_gpio_pkg.sv */
package sense_pin_gpio_pkg;

  // Bus geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int IDX_W = 14;
  localparam int REG_W = 8;
  localparam int SENSE_PINS = 5;
  localparam int SYNC_STAGES = 2;

  // Printed offsets are word indexes; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_INDICATOR_SECOND_CONTROL = 14'h0807;
  localparam logic [IDX_W-1:0] IDX_SENSE_PINS_PULLDOWN_ENABLE = 14'h082D;
  localparam logic [IDX_W-1:0] IDX_INDICATOR_PIN_PULLDOWN_ENABLE = 14'h082F;
  localparam logic [IDX_W-1:0] IDX_SENSE_PINS_DIRECTION = 14'h0831;
  localparam logic [IDX_W-1:0] IDX_INDICATOR_PIN_DIRECTION = 14'h0833;
  localparam logic [IDX_W-1:0] IDX_SENSE_PINS_OUTPUT_VALUE = 14'h0835;
  localparam logic [IDX_W-1:0] IDX_INDICATOR_PIN_OUTPUT_VALUE = 14'h0837;
  localparam logic [IDX_W-1:0] IDX_SENSE_PINS_INPUT_LEVEL = 14'h0839;
  localparam logic [IDX_W-1:0] IDX_INDICATOR_PIN_INPUT_LEVEL = 14'h083B;
  localparam logic [IDX_W-1:0] IDX_SENSE_PINS_PULLUP_ENABLE = 14'h083D;
  localparam logic [IDX_W-1:0] IDX_INDICATOR_PIN_PULLUP_ENABLE = 14'h083F;

  // Field positions
  localparam int VBUS_BIT = 0;
  localparam int INDICATOR_BIT = 0;
  localparam int ROLE_SELECT_BIT = 0;
  localparam int WORD_LSB = 2;
  localparam int DATA_LANE = 0;

  // Reset values
  localparam logic [REG_W-1:0] REG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;
  localparam logic [1:0] ALIGNED = 2'h0;

endpackage

/* hdl/level_sync.sv */
`timescale 1ns/1ns
module level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  import sense_pin_gpio_pkg::*;

  // First stage feeds only the second stage
  logic [WIDTH-1:0] meta;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta <= '0;
      o_sync <= '0;
    end
    else
    begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule

/* hdl/pin_pad_ctrl.sv */
`timescale 1ns/1ns
module pin_pad_ctrl (
  input wire logic i_dir,
  input wire logic i_out_value,
  input wire logic i_pullup,
  input wire logic i_pulldown,
  input wire logic i_role_override,
  input wire logic i_override_value,
  output logic o_oe,
  output logic o_out,
  output logic o_pullup,
  output logic o_pulldown
);
  // An overriding role owns the buffer; the pulls stay under software control
  always_comb
  begin
    o_oe = i_role_override | i_dir;
    o_out = i_role_override ? i_override_value : i_out_value;
    o_pullup = i_pullup;
    o_pulldown = i_pulldown;
  end
endmodule

/* hdl/sense_pin_gpio_control.sv */
// Notes on behaviour
// - Sense pull-down register bits 0..4 enable VBUS and sense pad pull-downs.
// - Indicator pull-down register bit 0 enables the shared pad pull-down.
// - Sense direction bits 0..4: zero input, one output.
// - Indicator direction bit 0: zero input, one output.
// - Output-configured sense pads drive their sense output register bit.
// - Indicator output bit drives the general pin, ignored in indicator mode.
// - Sense input register is read-only sampled pad levels; bits 7..5 read zero.
// - Indicator input bit 0 returns sampled pad level; invalid in indicator mode.
// - Sense pull-up register bits 0..4 enable VBUS and sense pad pull-ups.
// - Indicator pull-up register bit 0 enables the shared pad pull-up.
// - Second control bit 0 selects general pin or engine-driven indicator.
`timescale 1ns/1ns
module sense_pin_gpio_control (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [sense_pin_gpio_pkg::ADDR_W-1:0] i_paddr,
  input wire logic [sense_pin_gpio_pkg::DATA_W-1:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [sense_pin_gpio_pkg::DATA_W-1:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [sense_pin_gpio_pkg::SENSE_PINS-1:0] i_sense_in,
  output logic [sense_pin_gpio_pkg::SENSE_PINS-1:0] o_sense_out,
  output logic [sense_pin_gpio_pkg::SENSE_PINS-1:0] o_sense_oe,
  output logic [sense_pin_gpio_pkg::SENSE_PINS-1:0] o_sense_pullup,
  output logic [sense_pin_gpio_pkg::SENSE_PINS-1:0] o_sense_pulldown,
  input wire logic i_indicator_in,
  input wire logic i_indicator_drive,
  output logic o_indicator_out,
  output logic o_indicator_oe,
  output logic o_indicator_pullup,
  output logic o_indicator_pulldown,
  output logic o_indicator_role
);
  import sense_pin_gpio_pkg::*;

  logic [1:0] rst_pipe;
  logic rst_n;
  logic [IDX_W-1:0] idx;
  logic aligned;
  logic mapped;
  logic read_only;
  logic setup_phase;
  logic access_phase;
  logic bus_write;
  logic [REG_W-1:0] next_rdata;
  logic [REG_W-1:0] sense_pulldown;
  logic [REG_W-1:0] indicator_pulldown;
  logic [REG_W-1:0] sense_direction;
  logic [REG_W-1:0] indicator_direction;
  logic [REG_W-1:0] sense_output;
  logic [REG_W-1:0] indicator_output;
  logic [REG_W-1:0] sense_pullup;
  logic [REG_W-1:0] indicator_pullup;
  logic [REG_W-1:0] indicator_control;
  logic [SENSE_PINS-1:0] sense_level;
  logic indicator_level;
  logic engine_drive;

  // Reset: asynchronous assertion, release through two flops
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rst_pipe <= 2'h0;
    end
    else
    begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end

  assign rst_n = rst_pipe[1];

  // Address decode
  assign idx = i_paddr[ADDR_W-1:WORD_LSB];
  assign aligned = (i_paddr[WORD_LSB-1:0] == ALIGNED);

  always_comb
  begin
    read_only = (idx == IDX_SENSE_PINS_INPUT_LEVEL) || (idx == IDX_INDICATOR_PIN_INPUT_LEVEL);
    unique case (idx)
      IDX_INDICATOR_SECOND_CONTROL, IDX_SENSE_PINS_PULLDOWN_ENABLE, IDX_INDICATOR_PIN_PULLDOWN_ENABLE,
      IDX_SENSE_PINS_DIRECTION, IDX_INDICATOR_PIN_DIRECTION, IDX_SENSE_PINS_OUTPUT_VALUE,
      IDX_INDICATOR_PIN_OUTPUT_VALUE, IDX_SENSE_PINS_INPUT_LEVEL, IDX_INDICATOR_PIN_INPUT_LEVEL,
      IDX_SENSE_PINS_PULLUP_ENABLE, IDX_INDICATOR_PIN_PULLUP_ENABLE: mapped = aligned;
      default: mapped = 1'b0;
    endcase
  end

  assign setup_phase = i_psel & ~i_penable;
  assign access_phase = i_psel & i_penable;
  // Only byte lane 0 carries register data; writes to read-only words are dropped
  assign bus_write = access_phase & i_pwrite & mapped & ~read_only & i_pstrb[DATA_LANE];

  // Zero wait states: read data is captured in the setup cycle
  assign o_pready = 1'b1;
  assign o_pslverr = access_phase & ~mapped;

  // Read mux
  always_comb
  begin
    next_rdata = REG_RESET;
    unique case (idx)
      IDX_INDICATOR_SECOND_CONTROL: next_rdata = indicator_control;
      IDX_SENSE_PINS_PULLDOWN_ENABLE: next_rdata = sense_pulldown;
      IDX_INDICATOR_PIN_PULLDOWN_ENABLE: next_rdata = indicator_pulldown;
      IDX_SENSE_PINS_DIRECTION: next_rdata = sense_direction;
      IDX_INDICATOR_PIN_DIRECTION: next_rdata = indicator_direction;
      IDX_SENSE_PINS_OUTPUT_VALUE: next_rdata = sense_output;
      IDX_INDICATOR_PIN_OUTPUT_VALUE: next_rdata = indicator_output;
      IDX_SENSE_PINS_INPUT_LEVEL: next_rdata[SENSE_PINS-1:0] = sense_level;
      IDX_INDICATOR_PIN_INPUT_LEVEL: next_rdata[INDICATOR_BIT] = indicator_level;
      IDX_SENSE_PINS_PULLUP_ENABLE: next_rdata = sense_pullup;
      IDX_INDICATOR_PIN_PULLUP_ENABLE: next_rdata = indicator_pullup;
      default: next_rdata = REG_RESET;
    endcase
    if (!aligned)
    begin
      next_rdata = REG_RESET;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_prdata <= RDATA_RESET;
    end
    else if (setup_phase && !i_pwrite)
    begin
      o_prdata <= {{(DATA_W-REG_W){1'b0}}, next_rdata};
    end
  end

  // Pull-down enables
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sense_pulldown <= REG_RESET;
      indicator_pulldown <= REG_RESET;
    end
    else if (bus_write)
    begin
      if (idx == IDX_SENSE_PINS_PULLDOWN_ENABLE)
      begin
        sense_pulldown <= i_pwdata[REG_W-1:0];
      end
      if (idx == IDX_INDICATOR_PIN_PULLDOWN_ENABLE)
      begin
        indicator_pulldown <= i_pwdata[REG_W-1:0];
      end
    end
  end

  // Pull-up enables
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sense_pullup <= REG_RESET;
      indicator_pullup <= REG_RESET;
    end
    else if (bus_write)
    begin
      if (idx == IDX_SENSE_PINS_PULLUP_ENABLE)
      begin
        sense_pullup <= i_pwdata[REG_W-1:0];
      end
      if (idx == IDX_INDICATOR_PIN_PULLUP_ENABLE)
      begin
        indicator_pullup <= i_pwdata[REG_W-1:0];
      end
    end
  end

  // Directions; reset leaves every pad an input so nothing is driven by surprise
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sense_direction <= REG_RESET;
      indicator_direction <= REG_RESET;
    end
    else if (bus_write)
    begin
      if (idx == IDX_SENSE_PINS_DIRECTION)
      begin
        sense_direction <= i_pwdata[REG_W-1:0];
      end
      if (idx == IDX_INDICATOR_PIN_DIRECTION)
      begin
        indicator_direction <= i_pwdata[REG_W-1:0];
      end
    end
  end

  // Output buffer data
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sense_output <= REG_RESET;
      indicator_output <= REG_RESET;
    end
    else if (bus_write)
    begin
      if (idx == IDX_SENSE_PINS_OUTPUT_VALUE)
      begin
        sense_output <= i_pwdata[REG_W-1:0];
      end
      if (idx == IDX_INDICATOR_PIN_OUTPUT_VALUE)
      begin
        indicator_output <= i_pwdata[REG_W-1:0];
      end
    end
  end

  // Role select; the bits above bit 0 are stored and read back but drive no output
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      indicator_control <= REG_RESET;
    end
    else if (bus_write && idx == IDX_INDICATOR_SECOND_CONTROL)
    begin
      indicator_control <= i_pwdata[REG_W-1:0];
    end
  end

  // Engine level is retimed so the pad data leaves a flop
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      engine_drive <= 1'b0;
    end
    else
    begin
      engine_drive <= i_indicator_drive;
    end
  end

  assign o_indicator_role = indicator_control[ROLE_SELECT_BIT];

  level_sync #(
    .WIDTH(SENSE_PINS + 1)
  ) u_input_sync (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_async({i_indicator_in, i_sense_in}),
    .o_sync({indicator_level, sense_level})
  );

  for (genvar g = 0; g < SENSE_PINS; g++)
  begin : g_sense_pad
    pin_pad_ctrl u_pad (
      .i_dir(sense_direction[g]),
      .i_out_value(sense_output[g]),
      .i_pullup(sense_pullup[g]),
      .i_pulldown(sense_pulldown[g]),
      .i_role_override(1'b0),
      .i_override_value(1'b0),
      .o_oe(o_sense_oe[g]),
      .o_out(o_sense_out[g]),
      .o_pullup(o_sense_pullup[g]),
      .o_pulldown(o_sense_pulldown[g])
    );
  end

  pin_pad_ctrl u_indicator_pad (
    .i_dir(indicator_direction[INDICATOR_BIT]),
    .i_out_value(indicator_output[INDICATOR_BIT]),
    .i_pullup(indicator_pullup[INDICATOR_BIT]),
    .i_pulldown(indicator_pulldown[INDICATOR_BIT]),
    .i_role_override(indicator_control[ROLE_SELECT_BIT]),
    .i_override_value(engine_drive),
    .o_oe(o_indicator_oe),
    .o_out(o_indicator_out),
    .o_pullup(o_indicator_pullup),
    .o_pulldown(o_indicator_pulldown)
  );

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!rst_n);

  property p_sense_pulldown;
    bus_write && idx == IDX_SENSE_PINS_PULLDOWN_ENABLE |=> o_sense_pulldown == $past(i_pwdata[SENSE_PINS-1:0]);
  endproperty
  a_sense_pulldown: assert property (p_sense_pulldown)
    else $error("sense pull-down does not follow write");
  property p_indicator_pulldown;
    bus_write && idx == IDX_INDICATOR_PIN_PULLDOWN_ENABLE |=> o_indicator_pulldown == $past(i_pwdata[INDICATOR_BIT]);
  endproperty
  a_indicator_pulldown: assert property (p_indicator_pulldown)
    else $error("indicator pull-down does not follow write");
  property p_sense_direction;
    bus_write && idx == IDX_SENSE_PINS_DIRECTION |=> o_sense_oe == $past(i_pwdata[SENSE_PINS-1:0]);
  endproperty
  a_sense_direction: assert property (p_sense_direction)
    else $error("sense output enables do not follow direction write");
  property p_indicator_direction;
    bus_write && idx == IDX_INDICATOR_PIN_DIRECTION && !o_indicator_role
      |=> o_indicator_oe == $past(i_pwdata[INDICATOR_BIT]);
  endproperty
  a_indicator_direction: assert property (p_indicator_direction)
    else $error("indicator enable does not follow direction write");
  property p_sense_output;
    bus_write && idx == IDX_SENSE_PINS_OUTPUT_VALUE |=> o_sense_out == $past(i_pwdata[SENSE_PINS-1:0]);
  endproperty
  a_sense_output: assert property (p_sense_output)
    else $error("sense pad data does not follow output write");
  property p_indicator_engine;
    o_indicator_role |-> o_indicator_oe && o_indicator_out == $past(i_indicator_drive);
  endproperty
  a_indicator_engine: assert property (p_indicator_engine)
    else $error("indicator mode pad not driven by engine");
  property p_sense_input_read;
    setup_phase && !i_pwrite && aligned && idx == IDX_SENSE_PINS_INPUT_LEVEL
      |=> o_prdata[REG_W-1:SENSE_PINS] == '0;
  endproperty
  a_sense_input_read: assert property (p_sense_input_read)
    else $error("sense input reserved bits not zero");
  property p_indicator_input_read;
    setup_phase && !i_pwrite && aligned && idx == IDX_INDICATOR_PIN_INPUT_LEVEL
      |=> o_prdata[INDICATOR_BIT] == $past(i_indicator_in, 3);
  endproperty
  a_indicator_input_read: assert property (p_indicator_input_read)
    else $error("indicator input read wrong level");
  property p_sense_pullup;
    bus_write && idx == IDX_SENSE_PINS_PULLUP_ENABLE |=> o_sense_pullup == $past(i_pwdata[SENSE_PINS-1:0]);
  endproperty
  a_sense_pullup: assert property (p_sense_pullup)
    else $error("sense pull-up does not follow write");
  property p_indicator_pullup;
    bus_write && idx == IDX_INDICATOR_PIN_PULLUP_ENABLE |=> o_indicator_pullup == $past(i_pwdata[INDICATOR_BIT]);
  endproperty
  a_indicator_pullup: assert property (p_indicator_pullup)
    else $error("indicator pull-up does not follow write");
  property p_role_select;
    bus_write && idx == IDX_INDICATOR_SECOND_CONTROL |=> o_indicator_role == $past(i_pwdata[ROLE_SELECT_BIT]);
  endproperty
  a_role_select: assert property (p_role_select)
    else $error("role select does not follow write");
  property p_input_latency;
    setup_phase && !i_pwrite && aligned && idx == IDX_SENSE_PINS_INPUT_LEVEL
      |=> o_prdata[SENSE_PINS-1:0] == $past(i_sense_in, 3);
  endproperty
  a_input_latency: assert property (p_input_latency)
    else $error("sense input not two-flop synchronised");
  // Read data was latched at the setup edge, so an unmapped read must already show zero
  property p_unmapped_error;
    access_phase && !mapped |-> o_pslverr && o_pready && (i_pwrite || o_prdata == RDATA_RESET);
  endproperty
  a_unmapped_error: assert property (p_unmapped_error)
    else $error("unmapped access not flagged");
endmodule

/* bench/pad_partner.sv */
`timescale 1ns/1ns
module pad_partner #(
  parameter int N = 1
) (
  input wire logic i_clk,
  input wire logic [N-1:0] i_oe,
  input wire logic [N-1:0] i_out,
  input wire logic [N-1:0] i_pu,
  input wire logic [N-1:0] i_pd,
  input wire logic [N-1:0] i_ext_en,
  input wire logic [N-1:0] i_ext,
  output logic [N-1:0] o_pad
);
  // A floating pad wanders each cycle, so nothing may rely on it
  logic [N-1:0] drift = '0;
  always @(posedge i_clk)
  begin
    drift <= ~drift;
  end
  always_comb
  begin
    for (int k = 0; k < N; k++)
    begin
      if (i_oe[k])
        o_pad[k] = i_out[k];
      else if (i_ext_en[k])
        o_pad[k] = i_ext[k];
      else if (i_pu[k])
        o_pad[k] = 1'b1;
      else if (i_pd[k])
        o_pad[k] = 1'b0;
      else
        o_pad[k] = drift[k];
    end
  end
endmodule

/* bench/sense_pin_gpio_control_tb_top.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module sense_pin_gpio_control_tb_top;
  import sense_pin_gpio_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [3:0] pstrb = 4'h0;
  logic [DATA_W-1:0] prdata;
  logic pready, pslverr;
  logic [4:0] s_in, s_out, s_oe, s_pu, s_pd;
  logic [4:0] ext_en = 5'h1f;
  logic [4:0] ext = 5'h00;
  logic i_in, i_out, i_oe, i_pu, i_pd, role;
  logic i_drv = 1'b0;
  logic iext_en = 1'b1;
  logic iext = 1'b0;
  int error_cnt, tests_run, cycles;
  int seed = 32'hdacb_6b23;
  logic [7:0] shadow [0:10];
  logic [4:0] exp_s;
  logic [4:0] exp_i;
  logic [IDX_W-1:0] idx_tab [0:10] = '{IDX_INDICATOR_SECOND_CONTROL, IDX_SENSE_PINS_PULLDOWN_ENABLE,
    IDX_INDICATOR_PIN_PULLDOWN_ENABLE, IDX_SENSE_PINS_DIRECTION, IDX_INDICATOR_PIN_DIRECTION,
    IDX_SENSE_PINS_OUTPUT_VALUE, IDX_INDICATOR_PIN_OUTPUT_VALUE, IDX_SENSE_PINS_INPUT_LEVEL,
    IDX_INDICATOR_PIN_INPUT_LEVEL, IDX_SENSE_PINS_PULLUP_ENABLE, IDX_INDICATOR_PIN_PULLUP_ENABLE};

  sense_pin_gpio_control dut (.i_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_sense_in(s_in), .o_sense_out(s_out),
    .o_sense_oe(s_oe), .o_sense_pullup(s_pu), .o_sense_pulldown(s_pd), .i_indicator_in(i_in),
    .i_indicator_drive(i_drv), .o_indicator_out(i_out), .o_indicator_oe(i_oe),
    .o_indicator_pullup(i_pu), .o_indicator_pulldown(i_pd), .o_indicator_role(role));
  pad_partner #(.N(5)) p_sense (.i_clk(clk), .i_oe(s_oe), .i_out(s_out), .i_pu(s_pu), .i_pd(s_pd),
    .i_ext_en(ext_en), .i_ext(ext), .o_pad(s_in));
  pad_partner #(.N(1)) p_ind (.i_clk(clk), .i_oe(i_oe), .i_out(i_out), .i_pu(i_pu), .i_pd(i_pd),
    .i_ext_en(iext_en), .i_ext(iext), .o_pad(i_in));

  initial
  begin
    forever #20 clk = ~clk;
  end

  task automatic wrap_up;
    if (error_cnt == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Pready is waited for, never assumed
  task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d, input logic [3:0] st,
    output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    pstrb <= st;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      error_cnt++;
      $display("mismatch at %0t: no pready", $time);
      wrap_up();
    end
  endtask

  task automatic wr(input int i, input logic [7:0] v);
    logic [31:0] rd;
    logic err;
    xfer(1'b1, {idx_tab[i], 2'b00}, v, 4'hf, rd, err);
    `CHK(err, 1'b0)
    if (i != 7 && i != 8)
      shadow[i] = v;
  endtask

  task automatic rdchk(input int i, input logic [7:0] e);
    logic [31:0] rd;
    logic err;
    xfer(1'b0, {idx_tab[i], 2'b00}, 8'h00, 4'h0, rd, err);
    `CHK(rd, {24'h00_0000, e})
    `CHK(err, 1'b0)
  endtask

  function automatic logic [4:0] lvl(input logic [4:0] oe, out, en, ex, pu);
    return (oe & out) | (~oe & en & ex) | (~oe & ~en & pu);
  endfunction

  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 6000)
    begin
      error_cnt++;
      $display("mismatch at %0t: timeout", $time);
      wrap_up();
    end
  end

  initial
  begin
    logic [31:0] rd;
    logic err;
    logic d;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 11; i++)
      rdchk(i, 8'h00);
    `CHK({s_oe, i_oe, s_pu, s_pd, role, s_out, i_out, i_pu, i_pd}, 25'h000_0000)
    for (int it = 0; it < 12; it++)
    begin
      for (int i = 1; i < 11; i++)
        if (i != 7 && i != 8)
          wr(i, it == 0 ? 8'hff : 8'($random(seed)));
      ext_en <= 5'($random(seed)) | ~(shadow[9][4:0] | shadow[1][4:0]);
      ext <= 5'($random(seed));
      iext_en <= 1'($random(seed)) | ~(shadow[10][0] | shadow[2][0]);
      iext <= 1'($random(seed));
      repeat (4) @(posedge clk);
      exp_s = lvl(shadow[3][4:0], shadow[5][4:0], ext_en, ext, shadow[9][4:0]);
      exp_i = lvl({4'h0, shadow[4][0]}, {4'h0, shadow[6][0]}, {4'h0, iext_en}, {4'h0, iext},
        {4'h0, shadow[10][0]});
      `CHK(s_pd, shadow[1][4:0])
      `CHK(i_pd, shadow[2][0])
      `CHK(s_oe, shadow[3][4:0])
      `CHK(i_oe, shadow[4][0])
      `CHK(s_out, shadow[5][4:0])
      `CHK(i_out, shadow[6][0])
      `CHK(s_pu, shadow[9][4:0])
      `CHK(i_pu, shadow[10][0])
      rdchk(7, {3'b000, exp_s});
      rdchk(8, {7'h00, exp_i[0]});
      for (int i = 1; i < 11; i++)
        if (i != 7 && i != 8)
          rdchk(i, shadow[i]);
    end
    wr(7, 8'hff);
    rdchk(7, {3'b000, exp_s});
    xfer(1'b1, {idx_tab[1], 2'b00}, ~shadow[1], 4'he, rd, err);
    rdchk(1, shadow[1]);
    xfer(1'b0, 16'h0000, 8'h00, 4'h0, rd, err);
    `CHK({err, rd}, 33'h1_0000_0000)
    xfer(1'b1, {idx_tab[3], 2'b01}, ~shadow[3], 4'hf, rd, err);
    `CHK(err, 1'b1)
    rdchk(3, shadow[3]);
    wr(0, 8'h01);
    @(posedge clk);
    `CHK(role, 1'b1)
    rdchk(0, 8'h01);
    // The engine level is re-timed by one flop, whatever the output bit holds
    repeat (16)
    begin
      d = 1'($random(seed));
      @(posedge clk);
      i_drv <= d;
      @(posedge clk);
      #1;
      `CHK({i_oe, i_out}, {1'b1, d})
    end
    wr(0, 8'h00);
    @(posedge clk);
    `CHK({role, i_out}, {1'b0, shadow[6][0]})
    wrap_up();
  end
endmodule
